// ===== tkn_pkg.sv
// ***********************************************************************
// shared constants and types of the token flag host controller
// ***********************************************************************
package tkn_pkg;
   // token space shape
   localparam int TKN_COUNT = 8; // number of token flags
   localparam int TKN_IDX_W = 3; // address bits that select a flag
   localparam int TKN_DATA_W = 16; // data pins of one port
   localparam int TKN_ADDR_W = 15; // address pins of one port
   // flag levels, active low
   localparam logic TKN_FLAG_TAKEN = 1'b0; // zero means held by this port
   localparam logic TKN_FLAG_FREE = 1'b1; // one means free or held by far port
   // pin levels
   localparam logic TKN_PIN_ACT = 1'b0; // active level of select, oe, write
   localparam logic TKN_PIN_IDLE = 1'b1; // inactive level of those pins
   // timing: each access phase lasts at least this long
   localparam int TKN_CLK_MHZ = 50; // clk_sys rate
   localparam int TKN_PHASE_NS = 40; // least time of one access phase
   localparam int TKN_PHASE_CYC = (TKN_PHASE_NS * TKN_CLK_MHZ + 999) / 1000;
   localparam int TKN_CNT_W = 8; // width of the phase counter
   // polling budget after a failed request
   localparam int TKN_POLL_LIMIT = 255; // further reads after the first failed one before the request is withdrawn
   localparam int TKN_POLL_W = 8; // width of the poll counter
   // user commands
   typedef enum logic [1:0] {
      op_acquire, // write zero, then read back
      op_release, // write one
      op_test,    // plain read of the flag
      op_init     // write one to every flag
   } tkn_op_type;
endpackage : tkn_pkg

// ===== tkn_acc_if.sv
`timescale 1ns/1ps
// ***********************************************************************
// one token space access, between the command engine and the sequencer
// ***********************************************************************
interface tkn_acc_if;
   import tkn_pkg::*;
   logic start; // one-cycle request for an access
   logic write; // high for a write, low for a read
   logic wbit; // value written to the flag
   logic [TKN_IDX_W-1:0] index; // flag to access
   logic busy; // sequencer is running an access
   logic done; // one-cycle pulse when the access and its gap end
   logic rflag; // flag value captured by the last read
   logic rmixed; // data bits of the last read disagreed
   // command engine side
   modport ctl (
      output start, write, wbit, index,
      input busy, done, rflag, rmixed
   );
   // pin sequencer side
   modport seq (
      input start, write, wbit, index,
      output busy, done, rflag, rmixed
   );
endinterface : tkn_acc_if

// ===== tkn_pin_seq.sv
`timescale 1ns/1ps
// ***********************************************************************
// pin sequencer: setup, strobe, end, gap; each phase PHASE_CYCLES long
// ***********************************************************************
module tkn_pin_seq
   import tkn_pkg::*;
#(
   parameter int PHASE_CYCLES = TKN_PHASE_CYC
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // access request
   tkn_acc_if.seq acc,
   // port pins
   output logic token_space_select_n,
   output logic oe_n,
   output logic rw_n,
   output logic [TKN_ADDR_W-1:0] addr,
   input wire logic [TKN_DATA_W-1:0] dq_in,
   output logic [TKN_DATA_W-1:0] dq_out,
   output logic dq_oe
);
   // refuse a phase length the counter cannot hold
   if (PHASE_CYCLES < 1 || PHASE_CYCLES >= (1 << TKN_CNT_W)) begin : g_chk
      $error("tkn_pin_seq: PHASE_CYCLES out of range");
   end

   localparam logic [TKN_CNT_W-1:0] LOAD = TKN_CNT_W'(PHASE_CYCLES - 1);

   typedef enum logic [2:0] {
      sq_idle, sq_setup, sq_strobe, sq_end, sq_gap
   } tkn_sq_type;

   tkn_sq_type st_q, st_d; // phase
   logic [TKN_CNT_W-1:0] cnt_q, cnt_d; // cycles left in a phase
   logic wr_q, wr_d; // access is a write
   logic sel_n_q, sel_n_d; // token space select pin
   logic oe_n_q, oe_n_d; // output enable pin
   logic rw_n_q, rw_n_d; // read/write pin
   logic [TKN_ADDR_W-1:0] addr_q, addr_d; // address pins
   logic [TKN_DATA_W-1:0] dq_q, dq_d; // write data
   logic dq_oe_q, dq_oe_d; // data drive enable
   logic flag_q, flag_d; // captured flag
   logic mixed_q, mixed_d; // read bits disagreed
   logic done_q, done_d; // end of access pulse
   logic tick; // current phase ends this cycle

   // ***********************************************************************
   // next state of the pins
   // ***********************************************************************
   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      wr_d = wr_q;
      sel_n_d = sel_n_q;
      oe_n_d = oe_n_q;
      rw_n_d = rw_n_q;
      addr_d = addr_q;
      dq_d = dq_q;
      dq_oe_d = dq_oe_q;
      flag_d = flag_q;
      mixed_d = mixed_q;
      done_d = 1'b0;
      tick = (cnt_q == '0);
      // phase counter reloads at each phase end
      if (st_q != sq_idle) begin
         cnt_d = tick ? LOAD : cnt_q - 1'b1;
      end
      case (st_q)
         sq_idle: begin
            // select the token space; high address bits stay low [RQ3]
            if (acc.start) begin
               st_d = sq_setup;
               cnt_d = LOAD;
               wr_d = acc.write;
               sel_n_d = TKN_PIN_ACT; // [RQ3]
               addr_d = TKN_ADDR_W'(acc.index);
               dq_d = {TKN_DATA_W{acc.wbit}}; // flag bit on every lane [RQ2]
               dq_oe_d = acc.write;
            end
         end
         sq_setup: begin
            // open the strobe like an ordinary static memory cycle [RQ3]
            if (tick) begin
               st_d = sq_strobe;
               if (wr_q) begin
                  rw_n_d = TKN_PIN_ACT;
               end else begin
                  oe_n_d = TKN_PIN_ACT;
               end
            end
         end
         sq_strobe: begin
            // write ends on the rising write pin, data still held [RQ20]
            if (tick) begin
               st_d = sq_end;
               rw_n_d = TKN_PIN_IDLE;
               oe_n_d = TKN_PIN_IDLE;
               if (!wr_q) begin
                  flag_d = dq_in[0];
                  mixed_d = !((&dq_in) || (~|dq_in));
               end
            end
         end
         sq_end: begin
            // release select so the next read recaptures the flag [RQ13]
            if (tick) begin
               st_d = sq_gap;
               sel_n_d = TKN_PIN_IDLE; // [RQ13]
               dq_oe_d = 1'b0;
            end
         end
         sq_gap: begin
            // select stays high for a full phase before the next access
            if (tick) begin
               st_d = sq_idle;
               done_d = 1'b1;
            end
         end
         default: begin
            st_d = sq_idle;
         end
      endcase
   end

   // ***********************************************************************
   // registers
   // ***********************************************************************
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= sq_idle;
         cnt_q <= '0;
         wr_q <= 1'b0;
         sel_n_q <= TKN_PIN_IDLE;
         oe_n_q <= TKN_PIN_IDLE;
         rw_n_q <= TKN_PIN_IDLE;
         addr_q <= '0;
         dq_q <= '0;
         dq_oe_q <= 1'b0;
         flag_q <= TKN_FLAG_FREE;
         mixed_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         wr_q <= wr_d;
         sel_n_q <= sel_n_d;
         oe_n_q <= oe_n_d;
         rw_n_q <= rw_n_d;
         addr_q <= addr_d;
         dq_q <= dq_d;
         dq_oe_q <= dq_oe_d;
         flag_q <= flag_d;
         mixed_q <= mixed_d;
         done_q <= done_d;
      end
   end

   // outputs
   assign token_space_select_n = sel_n_q;
   assign oe_n = oe_n_q;
   assign rw_n = rw_n_q;
   assign addr = addr_q;
   assign dq_out = dq_q;
   assign dq_oe = dq_oe_q;
   assign acc.busy = (st_q != sq_idle);
   assign acc.done = done_q;
   assign acc.rflag = flag_q;
   assign acc.rmixed = mixed_q;
endmodule : tkn_pin_seq

// ===== tkn_host.sv
`timescale 1ns/1ps
// Notes on behaviour
// RQ1: device holds eight token latches apart from memory
// RQ2: write zero requests, write one releases
// RQ3: select low, then ordinary static memory access
// RQ4: only three low address bits pick flag
// RQ5: device takes only data bit zero on writes
// RQ6: free flag taken reads zero here, one there
// RQ7: only the owner can change a held flag
// RQ8: owner writing one frees flag for both
// RQ9: non-owner zero waits in its request latch
// RQ10: release passes ownership to pending requester
// RQ11: reads replicate the flag on all bits
// RQ12: device latches read value while select and oe active
// RQ13: deassert select between successive reads
// RQ14: acquire by write zero, then read back
// RQ15: after failure keep polling or write one
// RQ16: simultaneous requests granted to exactly one port
// RQ17: write one to every token at start
// RQ18: flags gate no hardware resource
// RQ19: token accesses never add wait states
// RQ20: write lands at end of the write strobe
// ***********************************************************************
// token flag host: drives one port of the dual-port token space
// ***********************************************************************
module tkn_host
   import tkn_pkg::*;
#(
   parameter int PHASE_CYCLES = TKN_PHASE_CYC,
   parameter int POLL_LIMIT = TKN_POLL_LIMIT
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // user command
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire tkn_op_type cmd_op,
   input wire logic [TKN_IDX_W-1:0] cmd_index,
   input wire logic cmd_poll,
   // user answer
   output logic rsp_valid,
   output logic rsp_owned,
   output logic rsp_flag,
   output logic rsp_error,
   output logic init_done,
   // device port pins
   output logic token_space_select_n,
   output logic oe_n,
   output logic rw_n,
   output logic [TKN_ADDR_W-1:0] addr,
   input wire logic [TKN_DATA_W-1:0] dq_in,
   output logic [TKN_DATA_W-1:0] dq_out,
   output logic dq_oe
);
   // refuse a budget the poll counter cannot hold
   if (POLL_LIMIT < 0 || POLL_LIMIT >= (1 << TKN_POLL_W)) begin : g_chk
      $error("tkn_host: POLL_LIMIT out of range");
   end

   localparam logic [TKN_POLL_W-1:0] POLL_MAX = TKN_POLL_W'(POLL_LIMIT);
   localparam logic [TKN_IDX_W-1:0] IDX_LAST = TKN_IDX_W'(TKN_COUNT - 1);

   typedef enum logic [2:0] {
      st_init, st_idle, st_req_wr, st_check_rd,
      st_withdraw, st_rel_wr, st_test_rd, st_reply
   } tkn_st_type;

   tkn_acc_if acc (); // link to the pin sequencer

   tkn_st_type st_q, st_d; // command engine state
   logic [TKN_IDX_W-1:0] idx_q, idx_d; // flag being worked on
   logic poll_q, poll_d; // keep polling after a failed request
   logic [TKN_POLL_W-1:0] polls_q, polls_d; // reads done after failure
   logic pend_q, pend_d; // an access is in flight
   logic owned_q, owned_d; // answer: this port holds the flag
   logic flag_q, flag_d; // answer: flag as read
   logic err_q, err_d; // answer: read bits disagreed
   logic init_q, init_d; // all flags written free
   logic is_acc; // state runs a pin access
   logic acc_wr; // that access writes
   logic acc_bit; // value it writes

   // ***********************************************************************
   // pin sequencer
   // ***********************************************************************
   tkn_pin_seq #(
      .PHASE_CYCLES(PHASE_CYCLES)
   ) u_seq (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .acc(acc.seq),
      .token_space_select_n(token_space_select_n),
      .oe_n(oe_n),
      .rw_n(rw_n),
      .addr(addr),
      .dq_in(dq_in),
      .dq_out(dq_out),
      .dq_oe(dq_oe)
   );

   // ***********************************************************************
   // which access each state needs
   // ***********************************************************************
   always_comb begin
      is_acc = 1'b1;
      acc_wr = 1'b1;
      acc_bit = TKN_FLAG_FREE;
      case (st_q)
         st_init: acc_bit = TKN_FLAG_FREE; // clear every latch [RQ17]
         st_req_wr: acc_bit = TKN_FLAG_TAKEN; // request first [RQ14]
         st_check_rd: acc_wr = 1'b0; // then read back [RQ14]
         st_withdraw: acc_bit = TKN_FLAG_FREE; // drop the request [RQ15]
         st_rel_wr: acc_bit = TKN_FLAG_FREE; // release [RQ2]
         st_test_rd: acc_wr = 1'b0;
         default: is_acc = 1'b0;
      endcase
   end

   assign acc.start = is_acc && !pend_q && !acc.busy;
   assign acc.write = acc_wr;
   assign acc.wbit = acc_bit;
   assign acc.index = idx_q;

   // ***********************************************************************
   // command engine next state
   // ***********************************************************************
   always_comb begin
      st_d = st_q;
      idx_d = idx_q;
      poll_d = poll_q;
      polls_d = polls_q;
      owned_d = owned_q;
      flag_d = flag_q;
      err_d = err_q;
      init_d = init_q;
      pend_d = pend_q;
      // one access at a time
      if (acc.start) begin
         pend_d = 1'b1;
      end else if (acc.done) begin
         pend_d = 1'b0;
      end
      case (st_q)
         st_init: begin
            // walk all flags writing one [RQ17]
            if (acc.done) begin
               if (idx_q == IDX_LAST) begin
                  st_d = st_idle;
                  init_d = 1'b1;
               end else begin
                  idx_d = idx_q + 1'b1;
               end
            end
         end
         st_idle: begin
            // take a command
            if (cmd_valid) begin
               idx_d = cmd_index;
               poll_d = cmd_poll;
               polls_d = '0;
               err_d = 1'b0;
               case (cmd_op)
                  op_acquire: st_d = st_req_wr;
                  op_release: st_d = st_rel_wr;
                  op_test: st_d = st_test_rd;
                  op_init: begin
                     st_d = st_init;
                     idx_d = '0;
                     init_d = 1'b0;
                  end
                  default: st_d = st_idle;
               endcase
            end
         end
         st_req_wr: begin
            // zero written, now verify by reading [RQ14]
            if (acc.done) begin
               st_d = st_check_rd;
            end
         end
         st_check_rd: begin
            // owned only if the read returns zero [RQ14]
            if (acc.done) begin
               flag_d = acc.rflag;
               err_d = acc.rmixed;
               if (acc.rflag == TKN_FLAG_TAKEN) begin
                  owned_d = 1'b1;
                  st_d = st_reply;
               end else if (poll_q && polls_q != POLL_MAX) begin
                  // read again; the gap drops select first [RQ15] [RQ13]
                  polls_d = polls_q + 1'b1;
               end else begin
                  st_d = st_withdraw; // [RQ15]
               end
            end
         end
         st_withdraw: begin
            // pending request cleared, report failure
            if (acc.done) begin
               owned_d = 1'b0;
               st_d = st_reply;
            end
         end
         st_rel_wr: begin
            // token handed back
            if (acc.done) begin
               owned_d = 1'b0;
               flag_d = TKN_FLAG_FREE;
               st_d = st_reply;
            end
         end
         st_test_rd: begin
            // status only; not a way to acquire
            if (acc.done) begin
               flag_d = acc.rflag;
               err_d = acc.rmixed;
               owned_d = (acc.rflag == TKN_FLAG_TAKEN);
               st_d = st_reply;
            end
         end
         st_reply: begin
            // answer stands for this one cycle
            st_d = st_idle;
         end
         default: begin
            st_d = st_idle;
         end
      endcase
   end

   // ***********************************************************************
   // command engine registers
   // ***********************************************************************
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= st_init;
         idx_q <= '0;
         poll_q <= 1'b0;
         polls_q <= '0;
         pend_q <= 1'b0;
         owned_q <= 1'b0;
         flag_q <= TKN_FLAG_FREE;
         err_q <= 1'b0;
         init_q <= 1'b0;
      end else begin
         st_q <= st_d;
         idx_q <= idx_d;
         poll_q <= poll_d;
         polls_q <= polls_d;
         pend_q <= pend_d;
         owned_q <= owned_d;
         flag_q <= flag_d;
         err_q <= err_d;
         init_q <= init_d;
      end
   end

   // user side outputs
   assign cmd_ready = (st_q == st_idle);
   assign rsp_valid = (st_q == st_reply);
   assign rsp_owned = owned_q;
   assign rsp_flag = flag_q;
   assign rsp_error = err_q;
   assign init_done = init_q;
endmodule : tkn_host

// ===== tkn_host_checker.sv
`timescale 1ns/1ps
// *****
// pin and answer checks of the token host
// *****
module tkn_host_checker
   import tkn_pkg::*;
#(
   parameter int PHASE_CYCLES = TKN_PHASE_CYC
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // user side
   input wire logic cmd_valid,
   input wire logic cmd_ready,
   input wire tkn_op_type cmd_op,
   input wire logic rsp_valid,
   input wire logic rsp_owned,
   input wire logic rsp_flag,
   input wire logic rsp_error,
   input wire logic init_done,
   // device pins
   input wire logic token_space_select_n,
   input wire logic oe_n,
   input wire logic rw_n,
   input wire logic [TKN_ADDR_W-1:0] addr,
   input wire logic [TKN_DATA_W-1:0] dq_out,
   input wire logic dq_oe
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   localparam int WR_AT = PHASE_CYCLES + 2; // take to write strobe
   localparam int REL_AT = 4 * PHASE_CYCLES + 3; // take to release answer
   wire take = cmd_valid && cmd_ready; // command accepted
   property p_rep; dq_oe |-> dq_out == {TKN_DATA_W{dq_out[0]}}; endproperty
   a_rep: assert property (p_rep)
      else $error("write data not replicated");
   property p_addr;
      !token_space_select_n |-> addr[TKN_ADDR_W-1:TKN_IDX_W] == '0;
   endproperty
   a_addr: assert property (p_addr)
      else $error("high address bits set");
   property p_oe; !oe_n |-> rw_n && !dq_oe && !token_space_select_n;
   endproperty
   a_oe: assert property (p_oe)
      else $error("read strobe outside a clean read");
   property p_wr; !rw_n |-> dq_oe && !token_space_select_n && $stable(addr);
   endproperty
   a_wr: assert property (p_wr)
      else $error("write strobe without select or data");
   property p_wr_end; $rose(rw_n) |-> !token_space_select_n; endproperty
   a_wr_end: assert property (p_wr_end)
      else $error("write ended after select");
   property p_gap; $rose(token_space_select_n) |=> token_space_select_n;
   endproperty
   a_gap: assert property (p_gap)
      else $error("select gap too short");
   property p_ready; !init_done |-> !cmd_ready; endproperty
   a_ready: assert property (p_ready)
      else $error("ready before init");
   property p_rel; take && cmd_op == op_release |-> ##REL_AT rsp_valid;
   endproperty
   a_rel: assert property (p_rel)
      else $error("release answer late");
   property p_acq;
      take && cmd_op == op_acquire |-> ##WR_AT (!rw_n && !dq_out[0]);
   endproperty
   a_acq: assert property (p_acq)
      else $error("acquire does not start with write zero");
   property p_own; rsp_valid && !rsp_error |-> rsp_owned != rsp_flag;
   endproperty
   a_own: assert property (p_own)
      else $error("owned and flag disagree");
endmodule : tkn_host_checker

// ===== tkn_dev_model.sv
`timescale 1ns/1ps
// *****
// behavioural dual-port token space, port a faces the host
// *****
module tkn_dev_model
   import tkn_pkg::*;
(
   // port a pins
   input wire logic sel_a_n,
   input wire logic oe_a_n,
   input wire logic rw_a_n,
   input wire logic [TKN_ADDR_W-1:0] addr_a,
   input wire logic [TKN_DATA_W-1:0] d_a,
   output logic [TKN_DATA_W-1:0] q_a,
   // port b pins
   input wire logic sel_b_n,
   input wire logic oe_b_n,
   input wire logic rw_b_n,
   input wire logic [TKN_ADDR_W-1:0] addr_b,
   input wire logic [TKN_DATA_W-1:0] d_b,
   output logic [TKN_DATA_W-1:0] q_b
);
   logic [7:0] req_a = 8'h00; // stale requests at power-up
   logic [7:0] req_b = 8'hff; // request latches of port b
   logic [1:0] own [8] = '{default: 2'd1}; // 0 free 1 a 2 b
   logic lat_a = 1'b1; // output register a
   logic lat_b = 1'b1; // output register b
   wire wr_a = !sel_a_n && !rw_a_n;
   wire wr_b = !sel_b_n && !rw_b_n;
   wire rd_a = !sel_a_n && !oe_a_n;
   wire rd_b = !sel_b_n && !oe_b_n;
   // owner keeps it, else a pending request takes over
   function automatic logic [1:0] settle(logic [1:0] o, logic ra, logic rb);
      if (o == 2'd1 && !ra) return o;
      if (o == 2'd2 && !rb) return o;
      if (!ra) return 2'd1; // earlier or tied request wins
      if (!rb) return 2'd2;
      return 2'd0;
   endfunction : settle
   // writes land at strobe end, bit zero, three index bits
   always @(negedge wr_a) begin
      req_a[addr_a[2:0]] = d_a[0]; // held request stays latched
      own[addr_a[2:0]] = settle(own[addr_a[2:0]], d_a[0], req_b[addr_a[2:0]]);
   end
   always @(negedge wr_b) begin
      req_b[addr_b[2:0]] = d_b[0];
      own[addr_b[2:0]] = settle(own[addr_b[2:0]], req_a[addr_b[2:0]], d_b[0]);
   end
   // capture on read start, held while active
   always @(posedge rd_a) lat_a = own[addr_a[2:0]] != 2'd1;
   always @(posedge rd_b) lat_b = own[addr_b[2:0]] != 2'd2;
   // replicated data, inverse when released, no wait
   assign q_a = rd_a ? {TKN_DATA_W{lat_a}} : {TKN_DATA_W{!lat_a}};
   assign q_b = rd_b ? {TKN_DATA_W{lat_b}} : {TKN_DATA_W{!lat_b}};
endmodule : tkn_dev_model

// ===== tb_tkn_host.sv
`timescale 1ns/1ps
module tb_tkn_host;
   import tkn_pkg::*;
   // *****
   // signals
   // *****
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic cmd_valid = 1'b0;
   tkn_op_type cmd_op = op_test;
   logic [TKN_IDX_W-1:0] cmd_index = '0;
   logic cmd_poll = 1'b0;
   logic cmd_ready, rsp_valid, rsp_owned, rsp_flag, rsp_error, init_done;
   logic token_space_select_n, oe_n, rw_n, dq_oe;
   logic [TKN_ADDR_W-1:0] addr;
   logic [TKN_DATA_W-1:0] dq_out, q_a, q_b;
   wire [TKN_DATA_W-1:0] bus_a = dq_oe ? dq_out : q_a; // shared data wire
   logic sel_b_n = 1'b1, oe_b_n = 1'b1, rw_b_n = 1'b1; // far port pins
   logic [TKN_ADDR_W-1:0] addr_b = '0;
   logic [TKN_DATA_W-1:0] d_b = '0;
   int err_count = 0;
   int checked = 0;
   tkn_host #(.PHASE_CYCLES(2), .POLL_LIMIT(2)) dut (.clk_sys, .rst_n,
      .cmd_valid, .cmd_ready, .cmd_op, .cmd_index, .cmd_poll, .rsp_valid,
      .rsp_owned, .rsp_flag, .rsp_error, .init_done, .token_space_select_n,
      .oe_n, .rw_n, .addr, .dq_in(bus_a), .dq_out, .dq_oe);
   tkn_dev_model u_dev (.sel_a_n(token_space_select_n), .oe_a_n(oe_n),
      .rw_a_n(rw_n), .addr_a(addr), .d_a(bus_a), .q_a, .sel_b_n, .oe_b_n,
      .rw_b_n, .addr_b, .d_b, .q_b);
   initial forever #10 clk_sys = ~clk_sys;
   // *****
   // helpers
   // *****
   task automatic fail(input string msg);
      err_count++;
      $display("BAD t=%0t %s", $time, msg);
   endtask : fail
   task automatic chk(input logic got, input logic exp, input string msg);
      checked++;
      if (got !== exp) fail(msg);
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : tick
   task automatic print_verdict;
      $display("checks %0d errors %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : print_verdict
   // one host command, bounded waits
   task automatic cmd(input tkn_op_type op, input int idx, input logic poll);
      int n;
      n = 0;
      while (cmd_ready !== 1'b1 && n < 500) begin
         tick(1);
         n++;
      end
      cmd_valid = 1'b1;
      cmd_op = op;
      cmd_index = idx[2:0];
      cmd_poll = poll;
      tick(1);
      cmd_valid = 1'b0;
      while (rsp_valid !== 1'b1 && n < 500) begin
         tick(1);
         n++;
      end
      if (n >= 500) begin
         fail("command timed out");
         print_verdict();
      end
   endtask : cmd
   // far port write, high address bits set on purpose
   task automatic b_wr(input int idx, input logic v);
      addr_b = {12'hfff, idx[2:0]};
      d_b = {TKN_DATA_W{!v}};
      d_b[0] = v;
      sel_b_n = 1'b0;
      tick(1);
      rw_b_n = 1'b0;
      tick(2);
      rw_b_n = 1'b1;
      tick(1);
      sel_b_n = 1'b1;
      tick(1);
   endtask : b_wr
   // far port read and compare of all data bits
   task automatic b_rd(input int idx, input logic exp);
      addr_b = {12'hfff, idx[2:0]};
      sel_b_n = 1'b0;
      oe_b_n = 1'b0;
      tick(2);
      checked++;
      if (q_b !== {TKN_DATA_W{exp}}) fail("far port flag wrong");
      oe_b_n = 1'b1;
      sel_b_n = 1'b1;
      tick(1);
   endtask : b_rd
   // *****
   // scenarios
   // *****
   task automatic t_init;
      int n;
      n = 0;
      while (init_done !== 1'b1 && n < 500) begin
         tick(1);
         n++;
      end
      chk(init_done, 1'b1, "init never ends");
      if (init_done !== 1'b1) print_verdict();
      for (int i = 0; i < 8; i++) b_rd(i, 1'b1);
   endtask : t_init
   task automatic t_grant;
      cmd(op_acquire, 3, 1'b0);
      chk(rsp_owned, 1'b1, "acquire failed");
      chk(rsp_flag, 1'b0, "flag not low");
      b_rd(3, 1'b1);
      b_wr(3, 1'b1);
      b_rd(3, 1'b1);
      b_wr(3, 1'b0);
      b_rd(3, 1'b1);
      cmd(op_test, 3, 1'b0);
      chk(rsp_flag, 1'b0, "test lost flag");
      cmd(op_release, 3, 1'b0);
      chk(rsp_owned, 1'b0, "still owned");
      b_rd(3, 1'b0);
   endtask : t_grant
   task automatic t_fail;
      cmd(op_acquire, 3, 1'b0);
      chk(rsp_owned, 1'b0, "held flag granted");
      chk(rsp_error, 1'b0, "mixed read");
      b_wr(3, 1'b1);
      b_rd(3, 1'b1);
      cmd(op_test, 3, 1'b0);
      chk(rsp_flag, 1'b1, "flag not free");
   endtask : t_fail
   task automatic t_poll;
      b_wr(5, 1'b0);
      fork
         cmd(op_acquire, 5, 1'b1);
         begin
            tick(14);
            b_wr(5, 1'b1);
         end
      join
      chk(rsp_owned, 1'b1, "poll did not win");
      b_rd(5, 1'b1);
      cmd(op_release, 5, 1'b0);
   endtask : t_poll
   // host write lands 1 ns before the far write, in the same cycle, so the host wins
   task automatic t_race;
      fork
         cmd(op_acquire, 2, 1'b0);
         begin
            tick(4);
            b_wr(2, 1'b0);
         end
      join
      chk(rsp_owned, 1'b1, "earlier request lost");
      b_rd(2, 1'b1);
      cmd(op_release, 2, 1'b0);
      b_rd(2, 1'b0);
      b_wr(2, 1'b1);
   endtask : t_race
   task automatic t_all;
      for (int i = 0; i < 8; i++) begin
         cmd(op_acquire, i, 1'b0);
         chk(rsp_owned, 1'b1, "index acquire failed");
         b_rd(i, 1'b1);
         cmd(op_release, i, 1'b0);
         b_rd(i, 1'b1);
      end
   endtask : t_all
   // start-up clear issued again from the command port
   task automatic t_reinit;
      int n;
      n = 0;
      cmd(op_acquire, 6, 1'b0);
      tick(1);
      cmd_valid = 1'b1;
      cmd_op = op_init;
      tick(1);
      cmd_valid = 1'b0;
      chk(init_done, 1'b0, "init_done kept during re-init");
      while (init_done !== 1'b1 && n < 500) begin
         tick(1);
         n++;
      end
      chk(init_done, 1'b1, "re-init never ends");
      if (init_done !== 1'b1) print_verdict();
      cmd(op_test, 6, 1'b0);
      chk(rsp_flag, 1'b1, "init left flag held");
   endtask : t_reinit
   // main sequence
   initial begin
      tick(2);
      rst_n = 1'b1;
      t_init();
      t_grant();
      t_fail();
      t_poll();
      t_race();
      t_all();
      t_reinit();
      print_verdict();
   end
endmodule : tb_tkn_host
bind tkn_host tkn_host_checker #(.PHASE_CYCLES(PHASE_CYCLES)) u_chk (
   .clk_sys, .rst_n, .cmd_valid, .cmd_ready, .cmd_op, .rsp_valid, .rsp_owned,
   .rsp_flag, .rsp_error, .init_done, .token_space_select_n, .oe_n, .rw_n,
   .addr, .dq_out, .dq_oe);
